// >>> rtl/rfo_mem_if.sv
interface rfo_mem_if;
  logic we;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// >>> rtl/rfo_pkg.sv
package rfo_pkg;
  localparam int RFO_ADDR_W = 16;
  localparam int RFO_DATA_W = 8;
  localparam logic [11:0] RFO_APB_CTRL_OFS = 12'h000;
  localparam logic [11:0] RFO_APB_RAMBASE_OFS = 12'h100;
  localparam logic [11:0] RFO_APB_FLBASE_OFS = 12'h800;
  localparam logic [11:0] RFO_APB_STAT_OFS = 12'h004;
  localparam int RFO_SEL_HI_POS = 7;
  localparam int RFO_SEL_LO_POS = 6;
  localparam logic [7:0] RFO_CTRL_RST = 8'h08;
  localparam logic [15:0] RFO_RAM_BASE = 16'hFC00;
  localparam logic [15:0] RFO_RAM_LAST = 16'hFD7F;
  localparam logic [15:0] RFO_WIN01_RAM_LO = 16'hFC80;
  localparam logic [15:0] RFO_WIN01_RAM_HI = 16'hFCFF;
  localparam logic [15:0] RFO_WIN01_FL_LO = 16'h0080;
  localparam logic [15:0] RFO_WIN01_FL_HI = 16'h00FF;
  localparam logic [15:0] RFO_WIN10_RAM_LO = 16'hFC80;
  localparam logic [15:0] RFO_WIN10_RAM_HI = 16'hFD7F;
  localparam logic [15:0] RFO_WIN10_FL_LO = 16'h0080;
  localparam logic [15:0] RFO_WIN10_FL_HI = 16'h017F;
  localparam logic [15:0] RFO_WIN11_RAM_LO = 16'hFC00;
  localparam logic [15:0] RFO_WIN11_RAM_HI = 16'hFC7F;
  localparam logic [15:0] RFO_WIN11_FL_LO = 16'h0000;
  localparam logic [15:0] RFO_WIN11_FL_HI = 16'h007F;
  localparam int RFO_RAM_DEPTH = 384;
  localparam int RFO_RAM_AW = 9;
  localparam int RFO_FL_DEPTH = 512;
  localparam int RFO_FL_AW = 9;
  localparam logic [7:0] RFO_FL_ERASED = 8'hFF;
endpackage

// >>> rtl/rfo_ram.sv
module rfo_ram
  import rfo_pkg::*;
#(
  parameter int DEPTH = RFO_RAM_DEPTH,
  parameter logic [7:0] INIT = 8'h00
) (
  input wire logic clk,
  rfo_mem_if.mem port
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rd_reg;
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_q[i] = INIT;
    end
  end
  always_ff @(posedge clk) begin
    if (port.we && (int'(port.addr) < DEPTH)) begin
      mem_q[port.addr] <= port.wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (int'(port.addr) < DEPTH) begin
      rd_reg <= mem_q[port.addr];
    end else begin
      rd_reg <= 8'h00;
    end
  end
  assign port.rdata = rd_reg;
endmodule

// >>> rtl/rfo_top.sv
// Operation
// - bits 7 and 6 of wait-state register select overlap; both zero means none
// - select 01 maps RAM FC80-FCFF onto flash 0080-00FF
// - select 10 maps RAM FC80-FD7F onto flash 0080-017F
// - select 11 maps RAM FC00-FC7F onto flash 0000-007F
// - remapped RAM reachable at both addresses, one shared storage
// - writes to overlapped flash addresses update the backing RAM
// - clearing both bits releases overlap at once; RAM keeps data
// - register reinitialised by reset and hardware standby, kept in software standby
// - exactly one select bit set blocks program and erase; verify allowed
//
// Implementation choices: the APB interface to the registers and the register offsets.
module rfo_top
  import rfo_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic HW_STANDBY,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [rfo_pkg::RFO_DATA_W-1:0] OVL_CTRL_OUT,
  output logic OVERLAP_ACTIVE,
  output logic PROG_ERASE_BLOCK
);
  import rfo_pkg::*;

  typedef enum logic [2:0] {
    RFO_IDLE = 3'b001,
    RFO_WAIT = 3'b010,
    RFO_DONE = 3'b100
  } rfo_state_e;

  rfo_mem_if ram_bus ();
  rfo_mem_if fl_bus ();

  rfo_ram #(.DEPTH(RFO_RAM_DEPTH), .INIT(8'h00)) u_ram (
    .clk(REF_CLK),
    .port(ram_bus)
  );
  rfo_ram #(.DEPTH(RFO_FL_DEPTH), .INIT(RFO_FL_ERASED)) u_flash (
    .clk(REF_CLK),
    .port(fl_bus)
  );

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  rfo_state_e state_reg;
  rfo_state_e state_next;
  logic [31:0] rdata_reg;
  logic ready_reg;
  logic slverr_reg;
  logic err_reg;
  logic sel_ram_reg;
  logic ovl_reg;
  logic blk_reg;

  logic setup;
  logic commit;
  logic [11:0] ofs;
  logic [15:0] cpu_addr;
  logic is_ctrl;
  logic is_stat;
  logic is_ram_space;
  logic is_fl_space;
  logic hit_ram;
  logic [8:0] ram_idx;
  logic mapped;

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // translate a flash address to a ram index when the current window covers it
  function automatic logic win_hit(input logic [1:0] sel, input logic [15:0] a, output logic [8:0] idx);
    logic [15:0] d;
    d = 16'h0000;
    win_hit = 1'b0;
    case (sel)
      2'b01: begin
        win_hit = in_rng(a, RFO_WIN01_FL_LO, RFO_WIN01_FL_HI);
        d = a - RFO_WIN01_FL_LO + RFO_WIN01_RAM_LO - RFO_RAM_BASE;
      end
      2'b10: begin
        win_hit = in_rng(a, RFO_WIN10_FL_LO, RFO_WIN10_FL_HI);
        d = a - RFO_WIN10_FL_LO + RFO_WIN10_RAM_LO - RFO_RAM_BASE;
      end
      2'b11: begin
        win_hit = in_rng(a, RFO_WIN11_FL_LO, RFO_WIN11_FL_HI);
        d = a - RFO_WIN11_FL_LO + RFO_WIN11_RAM_LO - RFO_RAM_BASE;
      end
      default: begin
        win_hit = 1'b0;
        d = 16'h0000;
      end
    endcase
    idx = d[8:0];
  endfunction

  assign setup = PSEL && !PENABLE;
  // writes land on the edge that completes the transfer, never earlier
  assign commit = (state_reg == RFO_DONE) && PSEL && PENABLE && PWRITE;
  assign ofs = {PADDR[11:2], 2'b00};
  assign is_ctrl = (ofs == RFO_APB_CTRL_OFS) && (PADDR[31:12] == 20'h00000);
  assign is_stat = (ofs == RFO_APB_STAT_OFS) && (PADDR[31:12] == 20'h00000);
  // ram view needs 0x600 bytes, so it sits below the flash view and never overlaps it
  assign is_ram_space = (PADDR[31:12] == 20'h00000) && !PADDR[11] && (ofs >= RFO_APB_RAMBASE_OFS);
  assign is_fl_space = (PADDR[31:12] == 20'h00000) && (PADDR[11] == 1'b1);

  // cpu-side address per word: ram window at FC00 + word index, flash at word index
  always_comb begin
    cpu_addr = 16'h0000;
    hit_ram = 1'b0;
    ram_idx = 9'h000;
    mapped = 1'b0;
    if (is_ram_space) begin
      cpu_addr = RFO_RAM_BASE + {7'h00, 9'(PADDR[10:2] - RFO_APB_RAMBASE_OFS[10:2])};
      hit_ram = in_rng(cpu_addr, RFO_RAM_BASE, RFO_RAM_LAST);
      ram_idx = 9'(cpu_addr - RFO_RAM_BASE);
      mapped = hit_ram;
    end else if (is_fl_space) begin
      cpu_addr = {7'h00, PADDR[10:2]};
      // overlap applies combinationally from the register, so a clear releases at once
      hit_ram = win_hit(ctrl_reg[RFO_SEL_HI_POS:RFO_SEL_LO_POS], cpu_addr, ram_idx);
      mapped = 1'b1;
    end
  end

  // one ram port serves both address views, so both reach identical storage
  always_comb begin
    ram_bus.addr = ram_idx;
    ram_bus.wdata = PWDATA[7:0];
    ram_bus.we = commit && hit_ram;
    fl_bus.addr = cpu_addr[8:0];
    fl_bus.wdata = PWDATA[7:0];
    // flash array is not programmed by cpu writes; program sequencing lives elsewhere
    fl_bus.we = 1'b0;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (commit && is_ctrl) begin
      ctrl_next = PWDATA[7:0];
    end
  end

  // software standby is not an input here: the register simply holds through it
  always_ff @(posedge REF_CLK) begin
    if (SRST || HW_STANDBY) begin
      ctrl_reg <= RFO_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RFO_IDLE: begin
        if (setup) begin
          state_next = RFO_WAIT;
        end
      end
      RFO_WAIT: state_next = RFO_DONE;
      RFO_DONE: state_next = RFO_IDLE;
      default: state_next = RFO_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_reg <= RFO_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sel_ram_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (state_reg == RFO_IDLE && setup) begin
      sel_ram_reg <= hit_ram;
      err_reg <= !(is_ctrl || is_stat || mapped);
    end
  end

  // memory read data arrives one cycle after setup, answered the cycle after that
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ready_reg <= 1'b0;
      slverr_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else if (state_reg == RFO_WAIT) begin
      ready_reg <= 1'b1;
      slverr_reg <= err_reg;
      if (err_reg || PWRITE) begin
        rdata_reg <= 32'h00000000;
      end else if (is_ctrl) begin
        rdata_reg <= {24'h000000, ctrl_reg};
      end else if (is_stat) begin
        rdata_reg <= {30'h0, blk_reg, ovl_reg};
      end else if (sel_ram_reg) begin
        rdata_reg <= {24'h000000, ram_bus.rdata};
      end else begin
        rdata_reg <= {24'h000000, fl_bus.rdata};
      end
    end else begin
      ready_reg <= 1'b0;
      slverr_reg <= 1'b0;
    end
  end

  // standby clears the flags with the register, so they never show a stale overlap
  always_ff @(posedge REF_CLK) begin
    if (SRST || HW_STANDBY) begin
      ovl_reg <= 1'b0;
      blk_reg <= 1'b0;
    end else begin
      ovl_reg <= |ctrl_next[RFO_SEL_HI_POS:RFO_SEL_LO_POS];
      // program/erase sequencer must honour this; verify paths ignore it
      blk_reg <= ^ctrl_next[RFO_SEL_HI_POS:RFO_SEL_LO_POS];
    end
  end

  // watchdog use while program/erase bits are set is left to software
  assign PRDATA = rdata_reg;
  assign PREADY = ready_reg;
  assign PSLVERR = slverr_reg;
  assign OVL_CTRL_OUT = ctrl_reg;
  assign OVERLAP_ACTIVE = ovl_reg;
  assign PROG_ERASE_BLOCK = blk_reg;
endmodule

// >>> tb/ram_flash_overlap_decoder_test.sv
module ram_flash_overlap_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, a) begin compares++; if ((e) !== (a)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, a); end end
  logic REF_CLK = 1'b0, SRST = 1'b1, HW_STANDBY = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, seed = 32'h00012494;
  logic PREADY, PSLVERR, OVERLAP_ACTIVE, PROG_ERASE_BLOCK, in;
  logic [7:0] OVL_CTRL_OUT, r, ram [384];
  logic [8:0] k, ka [8] = '{9'h000, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h17F, 9'h180, 9'h1FF};
  logic [1:0] mm;
  logic [33:0] e, q [$];
  int n_errors = 0, compares = 0;
  rfo_top dut_u (.REF_CLK(REF_CLK), .SRST(SRST), .HW_STANDBY(HW_STANDBY), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OVL_CTRL_OUT(OVL_CTRL_OUT), .OVERLAP_ACTIVE(OVERLAP_ACTIVE), .PROG_ERASE_BLOCK(PROG_ERASE_BLOCK));
  initial forever #50 REF_CLK = ~REF_CLK;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // for reads d is the expected data; the request is held until pready is seen
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic err);
    q.push_back({w, err, d});
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  always @(posedge REF_CLK) begin
    if (PREADY === 1'b1) begin
      e = q.pop_front();
      if (!e[33]) `CHK("prdata", e[31:0], PRDATA)
      `CHK("pslverr", e[32], PSLVERR)
    end
  end
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 384; i++) ram[i] = 8'h00;
    repeat (10) @(posedge REF_CLK);
    SRST <= 1'b0;
    apb(1'b0, 32'h0, 32'h08, 1'b0);
    // modes run 1,2,3 then 0, so the last pass checks release and retention
    for (int m = 1; m < 5; m++) begin
      mm = m[1:0];
      r = rnd();
      apb(1'b1, 32'h0, {24'h0, mm, r[5:0]}, 1'b0);
      apb(1'b0, 32'h0, {24'h0, mm, r[5:0]}, 1'b0);
      apb(1'b0, 32'h4, {30'h0, ^mm, |mm}, 1'b0);
      foreach (ka[j]) begin
        k = ka[j];
        in = (mm == 2'h1 && k >= 9'h080 && k <= 9'h0FF) || (mm == 2'h2 && k >= 9'h080 && k <= 9'h17F)
          || (mm == 2'h3 && k <= 9'h07F);
        r = rnd();
        apb(1'b1, 32'h800 + 4 * k, {24'h0, r}, 1'b0);
        if (in) ram[k] = r;
        apb(1'b0, 32'h800 + 4 * k, in ? {24'h0, ram[k]} : 32'hFF, 1'b0);
        if (k < 9'h180) apb(1'b0, 32'h100 + 4 * k, {24'h0, ram[k]}, 1'b0);
      end
      $display("mode %0d done", mm);
    end
    apb(1'b0, 32'h1000, 32'h0, 1'b1);
    // no program or erase bit is ever set here, so watchdog use never comes up
    apb(1'b1, 32'h0, 32'hC8, 1'b0);
    apb(1'b0, 32'h0, 32'hC8, 1'b0);
    @(posedge REF_CLK) HW_STANDBY <= 1'b1;
    @(posedge REF_CLK) HW_STANDBY <= 1'b0;
    apb(1'b0, 32'h0, 32'h08, 1'b0);
    $display("standby done");
    end_of_test();
  end
endmodule

// >>> tb/rfo_top_assertions.sv
module rfo_top_assertions (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic HW_STANDBY,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [rfo_pkg::RFO_DATA_W-1:0] OVL_CTRL_OUT,
  input wire logic OVERLAP_ACTIVE,
  input wire logic PROG_ERASE_BLOCK
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // status updates on the same edge as the register, yet is only judged once the register has settled
  AST_OVL: assert property ($stable(OVL_CTRL_OUT) |-> OVERLAP_ACTIVE == |OVL_CTRL_OUT[7:6])
    else $error("overlap flag wrong");
  AST_PEB: assert property ($stable(OVL_CTRL_OUT) |-> PROG_ERASE_BLOCK == ^OVL_CTRL_OUT[7:6])
    else $error("program block flag wrong");
  AST_STBY: assert property (HW_STANDBY |=> OVL_CTRL_OUT == 8'h08)
    else $error("standby did not reinit register");
  AST_HOLD: assert property (!HW_STANDBY && !(PSEL && PWRITE && PADDR == 32'h0) |=> $stable(OVL_CTRL_OUT))
    else $error("register changed without write");
  AST_WR: assert property (PREADY && PWRITE && PADDR == 32'h0 |=> OVL_CTRL_OUT == $past(PWDATA[7:0]))
    else $error("register write lost");
  AST_REL: assert property (PREADY && PWRITE && PADDR == 32'h0 && PWDATA[7:6] == 2'h0 |=> !OVERLAP_ACTIVE)
    else $error("overlap not released");
  AST_W01: assert property (PREADY && !PWRITE && PADDR == 32'hC00 && OVL_CTRL_OUT[7:6] == 2'h1 |-> PRDATA == 32'hFF)
    else $error("flash 100 remapped in mode 01");
  AST_W11: assert property (PREADY && !PWRITE && PADDR == 32'hA00 && OVL_CTRL_OUT[7:6] == 2'h3 |-> PRDATA == 32'hFF)
    else $error("flash 080 remapped in mode 11");
  CV_ERR: cover property (PREADY && PSLVERR);
  CV_STBY: cover property (HW_STANDBY);
  CV_BLK: cover property (OVERLAP_ACTIVE && PROG_ERASE_BLOCK);
endmodule
bind rfo_top rfo_top_assertions chk_u (.REF_CLK(REF_CLK), .SRST(SRST), .HW_STANDBY(HW_STANDBY), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .OVL_CTRL_OUT(OVL_CTRL_OUT), .OVERLAP_ACTIVE(OVERLAP_ACTIVE), .PROG_ERASE_BLOCK(PROG_ERASE_BLOCK));
